// ===== verilog/btct_timing.sv
// Purpose: baud generator and 16-bit counter/timer of one channel pair
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: rx load strobes come from logic on the same clock
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps

module btct_timing
	import btct_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register bus
	input wire btct_pkg::btct_ahb_req_t bus_req,
	output btct_pkg::btct_ahb_rsp_t bus_rsp,
	// receiver character loads
	input wire logic rx_load_a,
	input wire logic rx_load_b,
	// external counter/timer clock pin
	input wire logic ct_ext_pin,
	// outputs
	output logic ct_out,
	output logic ct_int_req,
	output logic [3:0] baud_tick,
	output logic [3:0] baud_x16
);
	import btct_pkg::*;

	// -------------------------------------------------------------
	// divisor lookup
	// -------------------------------------------------------------
	function automatic logic [12:0] brg_div(input logic grp, input logic [3:0] code);
		logic [12:0] d;
		d = 13'h0001;
		if (code <= CSEL_LAST_BRG) begin
			d = grp ? BRG_DIV_G1[code] : BRG_DIV_G0[code];
		end
		return d;
	endfunction

	function automatic logic [3:0] csel_code(input logic [7:0] a, input logic [7:0] b, input int i);
		logic [3:0] c;
		c = 4'h0;
		case (i)
			0: c = a[7:4];
			1: c = a[3:0];
			2: c = b[7:4];
			default: c = b[3:0];
		endcase
		return c;
	endfunction

	btct_state_t s_q;
	btct_state_t s_d;

	logic sys_en;
	logic ext_rise;
	logic base_tick;
	logic ct_tick;
	logic timer_mode;
	logic tmo_on;
	logic addr_ok;
	logic rd_ok;
	logic start_cmd;
	logic stop_cmd;
	logic rx_restart;
	logic clr_ready;
	logic ct_rise;
	logic [15:0] preload;
	logic [3:0] code;
	logic [12:0] div;

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		code = 4'h0;
		div = 13'h0001;
		clr_ready = 1'b0;

		// divided system enable; the baud dividers never use it
		s_d.half = s_q.div2 ? ~s_q.half : 1'b0;
		sys_en = ~s_q.div2 | s_q.half;

		// pin synchroniser, edge taken past the second stage
		s_d.sync = {s_q.sync[1:0], ct_ext_pin};
		ext_rise = s_q.sync[1] & ~s_q.sync[2];

		// counter/timer clock source
		base_tick = s_q.aux_control_reg[5] ? sys_en : ext_rise;
		if (base_tick) begin
			s_d.pre16 = s_q.pre16 + 4'h1;
		end
		ct_tick = base_tick;
		if (s_q.aux_control_reg[4]) begin
			ct_tick = base_tick & (s_q.pre16 == PRESCALE_LAST);
		end

		tmo_on = s_q.tmo_a | s_q.tmo_b;
		timer_mode = s_q.aux_control_reg[ACR_TIMER_BIT] & ~tmo_on;
		preload = {s_q.pre_hi, s_q.pre_lo};

		// ---------------------------------------------------------
		// bus address phase
		// ---------------------------------------------------------
		addr_ok = bus_req.hsel & bus_req.htrans[1] & bus_req.hready;
		rd_ok = addr_ok & ~bus_req.hwrite;
		s_d.wr_pend = addr_ok & bus_req.hwrite;
		s_d.wr_addr = bus_req.haddr;

		start_cmd = rd_ok & (bus_req.haddr == OFS_START) & ~tmo_on;
		stop_cmd = rd_ok & (bus_req.haddr == OFS_STOP) & ~tmo_on;

		if (rd_ok) begin
			s_d.rdata = 32'h0000_0000;
			if (bus_req.haddr == OFS_AUX_CTRL) begin
				s_d.rdata[7:0] = s_q.aux_control_reg;
			end else if (bus_req.haddr == OFS_INT_STATUS) begin
				s_d.rdata[ISR_CT_BIT] = s_q.isr_ct;
			end else if (bus_req.haddr == OFS_INT_MASK) begin
				s_d.rdata[7:0] = s_q.int_mask_reg;
			end else if (bus_req.haddr == OFS_PRE_HIGH) begin
				s_d.rdata[7:0] = s_q.pre_hi;
			end else if (bus_req.haddr == OFS_PRE_LOW) begin
				s_d.rdata[7:0] = s_q.pre_lo;
			end else if (bus_req.haddr == OFS_LIVE_HIGH) begin
				s_d.rdata[7:0] = s_q.cnt[15:8];
			end else if (bus_req.haddr == OFS_LIVE_LOW) begin
				s_d.rdata[7:0] = s_q.cnt[7:0];
			end else if (bus_req.haddr == OFS_CSEL_A) begin
				s_d.rdata[7:0] = s_q.csel_a;
			end else if (bus_req.haddr == OFS_CSEL_B) begin
				s_d.rdata[7:0] = s_q.csel_b;
			end else if (bus_req.haddr == OFS_CLK_OPT) begin
				s_d.rdata[OPT_DIV2_BIT] = s_q.div2;
			end
		end

		// ---------------------------------------------------------
		// counting
		// ---------------------------------------------------------
		if (ct_tick && s_q.run) begin
			if (timer_mode) begin
				// two reloads per period give the symmetric wave
				if (s_q.cnt <= 16'h0001) begin
					s_d.cnt = preload;
					s_d.ct_out = ~s_q.ct_out;
				end else begin
					s_d.cnt = s_q.cnt - 16'h0001;
				end
			end else begin
				// zero wraps to full scale and keeps going silently
				s_d.cnt = s_q.cnt - 16'h0001;
				if (s_q.cnt == 16'h0001 && !s_q.done) begin
					s_d.ct_out = 1'b0;
					s_d.done = 1'b1;
				end
			end
		end

		// character reload sequence in timeout mode
		if (ct_tick && s_q.reload == 2'h1) begin
			s_d.run = 1'b0;
			s_d.cnt = preload;
			s_d.reload = 2'h2;
		end else if (ct_tick && s_q.reload == 2'h2) begin
			s_d.run = 1'b1;
			s_d.reload = 2'h0;
		end

		rx_restart = (rx_load_a & s_q.tmo_a) | (rx_load_b & s_q.tmo_b);
		if (rx_restart) begin
			s_d.reload = 2'h1;
			s_d.ct_out = CT_OUT_RST;
			s_d.done = 1'b0;
			clr_ready = 1'b1;
		end

		if (start_cmd) begin
			s_d.cnt = preload;
			s_d.run = 1'b1;
			s_d.ct_out = CT_OUT_RST;
			s_d.done = 1'b0;
		end

		if (stop_cmd) begin
			clr_ready = 1'b1;
			if (!timer_mode) begin
				s_d.run = 1'b0;
			end
		end

		// ---------------------------------------------------------
		// bus data phase writes
		// ---------------------------------------------------------
		if (s_q.wr_pend) begin
			if (s_q.wr_addr == OFS_AUX_CTRL) begin
				s_d.aux_control_reg = bus_req.hwdata[7:0];
			end else if (s_q.wr_addr == OFS_INT_MASK) begin
				s_d.int_mask_reg = bus_req.hwdata[7:0];
			end else if (s_q.wr_addr == OFS_PRE_HIGH) begin
				s_d.pre_hi = bus_req.hwdata[7:0];
			end else if (s_q.wr_addr == OFS_PRE_LOW) begin
				s_d.pre_lo = bus_req.hwdata[7:0];
			end else if (s_q.wr_addr == OFS_CSEL_A) begin
				s_d.csel_a = bus_req.hwdata[7:0];
			end else if (s_q.wr_addr == OFS_CSEL_B) begin
				s_d.csel_b = bus_req.hwdata[7:0];
			end else if (s_q.wr_addr == OFS_CLK_OPT) begin
				s_d.div2 = bus_req.hwdata[OPT_DIV2_BIT];
			end else if (s_q.wr_addr == OFS_CMD_A || s_q.wr_addr == OFS_CMD_B) begin
				if (bus_req.hwdata[7:4] == CMD_TMO_ON) begin
					// held stopped until the next character arrives
					s_d.run = 1'b0;
					s_d.reload = 2'h0;
					s_d.ct_out = CT_OUT_RST;
					s_d.done = 1'b0;
					clr_ready = 1'b1;
					if (s_q.wr_addr == OFS_CMD_A) begin
						s_d.tmo_a = 1'b1;
					end else begin
						s_d.tmo_b = 1'b1;
					end
				end else if (bus_req.hwdata[7:4] == CMD_TMO_OFF) begin
					if (s_q.wr_addr == OFS_CMD_A) begin
						s_d.tmo_a = 1'b0;
					end else begin
						s_d.tmo_b = 1'b0;
					end
				end
			end
		end

		// ready flag: a falling edge in the same cycle as a clear wins
		s_d.isr_ct = (s_q.ct_out & ~s_d.ct_out) | (s_q.isr_ct & ~clr_ready);

		// ---------------------------------------------------------
		// baud dividers on the undivided clock
		// ---------------------------------------------------------
		s_d.out_prev = s_q.ct_out;
		ct_rise = s_q.ct_out & ~s_q.out_prev;
		for (int i = 0; i < 4; i++) begin
			code = csel_code(s_q.csel_a, s_q.csel_b, i);
			div = brg_div(s_q.aux_control_reg[ACR_GROUP_BIT], code);
			s_d.btick[i] = 1'b0;
			if (code == CSEL_CT) begin
				s_d.bcnt[i] = 13'h0000;
				s_d.btick[i] = ct_rise;
			end else if (code <= CSEL_LAST_BRG) begin
				if (s_q.bcnt[i] >= div - 13'h0001) begin
					s_d.bcnt[i] = 13'h0000;
					s_d.btick[i] = 1'b1;
				end else begin
					s_d.bcnt[i] = s_q.bcnt[i] + 13'h0001;
				end
			end else begin
				s_d.bcnt[i] = 13'h0000;
			end
		end
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.ct_out <= CT_OUT_RST;
			s_q.out_prev <= CT_OUT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	always_comb begin
		bus_rsp.hrdata = s_q.rdata;
		bus_rsp.hreadyout = 1'b1;
		bus_rsp.hresp = 1'b0;
		ct_out = s_q.ct_out;
		ct_int_req = s_q.isr_ct & s_q.int_mask_reg[ISR_CT_BIT];
		baud_tick = s_q.btick;
		for (int j = 0; j < 4; j++) begin
			baud_x16[j] = csel_code(s_q.csel_a, s_q.csel_b, j) <= CSEL_CT;
		end
	end

endmodule // btct_timing

// ===== verilog/btct_pkg.sv
// Purpose: shared constants and types for the baud and counter/timer block
// Assumes: one 100 MHz clock, AHB-Lite register access
// Notes: byte offsets are word aligned
package btct_pkg;

	// -------------------------------------------------------------
	// register byte offsets
	// -------------------------------------------------------------
	localparam logic [7:0] OFS_AUX_CTRL = 8'h00;
	localparam logic [7:0] OFS_INT_STATUS = 8'h04;
	localparam logic [7:0] OFS_INT_MASK = 8'h08;
	localparam logic [7:0] OFS_PRE_HIGH = 8'h0c;
	localparam logic [7:0] OFS_PRE_LOW = 8'h10;
	localparam logic [7:0] OFS_LIVE_HIGH = 8'h14;
	localparam logic [7:0] OFS_LIVE_LOW = 8'h18;
	localparam logic [7:0] OFS_START = 8'h1c;
	localparam logic [7:0] OFS_STOP = 8'h20;
	localparam logic [7:0] OFS_CMD_A = 8'h24;
	localparam logic [7:0] OFS_CMD_B = 8'h28;
	localparam logic [7:0] OFS_CSEL_A = 8'h2c;
	localparam logic [7:0] OFS_CSEL_B = 8'h30;
	localparam logic [7:0] OFS_CLK_OPT = 8'h34;

	// -------------------------------------------------------------
	// field positions and codes
	// -------------------------------------------------------------
	localparam int ACR_GROUP_BIT = 7;
	localparam int ACR_TIMER_BIT = 6;
	localparam int ISR_CT_BIT = 3;
	localparam int OPT_DIV2_BIT = 0;
	localparam logic [3:0] CMD_TMO_ON = 4'ha;
	localparam logic [3:0] CMD_TMO_OFF = 4'hc;
	localparam logic [3:0] CSEL_CT = 4'hd;
	localparam logic [3:0] CSEL_LAST_BRG = 4'hc;
	localparam logic [1:0] SRC_PIN = 2'h0;
	localparam logic [1:0] SRC_PIN16 = 2'h1;
	localparam logic [1:0] SRC_XTAL = 2'h2;
	localparam logic [3:0] PRESCALE_LAST = 4'hf;
	localparam logic [15:0] CT_FULL_SCALE = 16'hffff;
	localparam logic CT_OUT_RST = 1'b1;

	// -------------------------------------------------------------
	// 16x divisors, crystal cycles per tick; defaults, plain values
	// -------------------------------------------------------------
	localparam logic [12:0] BRG_DIV_G0 [13] = '{
		13'h1200, 13'h082f, 13'h06b1, 13'h0480, 13'h0300, 13'h0180, 13'h00c0,
		13'h00db, 13'h0060, 13'h0030, 13'h0020, 13'h0018, 13'h0006};
	localparam logic [12:0] BRG_DIV_G1 [13] = '{
		13'h0c00, 13'h082f, 13'h06b1, 13'h0600, 13'h0300, 13'h0180, 13'h00c0,
		13'h0073, 13'h0060, 13'h0030, 13'h0080, 13'h0018, 13'h000c};

	// -------------------------------------------------------------
	// carriers
	// -------------------------------------------------------------
	typedef struct packed {
		logic hsel;
		logic [7:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} btct_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} btct_ahb_rsp_t;

	typedef struct packed {
		logic [7:0] aux_control_reg;
		logic [7:0] int_mask_reg;
		logic [7:0] pre_hi;
		logic [7:0] pre_lo;
		logic [7:0] csel_a;
		logic [7:0] csel_b;
		logic div2;
		logic half;
		logic [15:0] cnt;
		logic ct_out;
		logic out_prev;
		logic run;
		logic done;
		logic isr_ct;
		logic tmo_a;
		logic tmo_b;
		logic [1:0] reload;
		logic [2:0] sync;
		logic [3:0] pre16;
		logic [3:0][12:0] bcnt;
		logic [3:0] btick;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} btct_state_t;

endpackage

// ===== tb/btct_properties.sv
// Purpose: port checker for btct_timing
// Assumes: timeout state is tracked from command writes
// Notes: bound to the design after the module
`timescale 1ns/1ps
module btct_properties
	import btct_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// bus
	input wire btct_pkg::btct_ahb_req_t bus_req,
	input wire btct_pkg::btct_ahb_rsp_t bus_rsp,
	// receiver loads and pin
	input wire logic rx_load_a,
	input wire logic rx_load_b,
	input wire logic ct_ext_pin,
	// outputs
	input wire logic ct_out,
	input wire logic ct_int_req,
	input wire logic [3:0] baud_tick,
	input wire logic [3:0] baud_x16
);
	logic wr_q, ta_q, tb_q;
	logic [7:0] wa_q;
	wire logic tk = bus_req.hsel && bus_req.htrans[1] && bus_req.hready;
	wire logic [3:0] cmd = bus_req.hwdata[7:4];
	wire logic on_ev = wr_q && (wa_q == OFS_CMD_A || wa_q == OFS_CMD_B) && cmd == CMD_TMO_ON;
	wire logic rd_t = tk && !bus_req.hwrite && !ta_q && !tb_q;
	wire logic mw = wr_q && wa_q == OFS_INT_MASK;
	wire logic [1:0] xa = {bus_req.hwdata[3:0] < 4'he, bus_req.hwdata[7:4] < 4'he};
	// command writes land at the end of the data phase
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_q <= 1'b0;
			ta_q <= 1'b0;
			tb_q <= 1'b0;
		end else begin
			wr_q <= tk && bus_req.hwrite;
			wa_q <= bus_req.haddr;
			if (wr_q && wa_q == OFS_CMD_A && (cmd == CMD_TMO_ON || cmd == CMD_TMO_OFF)) begin
				ta_q <= cmd == CMD_TMO_ON;
			end
			if (wr_q && wa_q == OFS_CMD_B && (cmd == CMD_TMO_ON || cmd == CMD_TMO_OFF)) begin
				tb_q <= cmd == CMD_TMO_ON;
			end
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence quiet8;
		(!rx_load_a && !rx_load_b)[*8];
	endsequence
	AST_RST_OUT: assert property (disable iff (1'b0)
		sys_rst |=> ct_out && !ct_int_req && baud_tick == 4'h0 && baud_x16 == 4'hf) else $error("bad reset outputs");
	AST_START: assert property (rd_t && bus_req.haddr == OFS_START |=> ct_out)
		else $error("start did not raise output");
	AST_TMO_HOLD: assert property (on_ev ##1 quiet8 |-> ct_out)
		else $error("counter ran before a character");
	AST_RX_CLR: assert property ((ta_q && rx_load_a) || (tb_q && rx_load_b) |=> ct_out && !ct_int_req)
		else $error("character did not restart");
	AST_STOP_CLR: assert property (rd_t && bus_req.haddr == OFS_STOP |=> !ct_int_req || $fell(ct_out))
		else $error("stop did not clear ready");
	AST_INT_FALL: assert property ($rose(ct_int_req) |-> $fell(ct_out) || $past(mw))
		else $error("request without falling output");
	AST_TICK: assert property (baud_tick != 4'h0 |=> (baud_tick & $past(baud_tick)) == 4'h0)
		else $error("tick longer than one cycle");
	AST_X16: assert property (wr_q && wa_q == OFS_CSEL_A |=> baud_x16[1:0] == $past(xa))
		else $error("sampling mode mismatch");
endmodule // btct_properties

bind btct_timing btct_properties u_props (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
	.rx_load_a(rx_load_a), .rx_load_b(rx_load_b), .ct_ext_pin(ct_ext_pin), .ct_out(ct_out),
	.ct_int_req(ct_int_req), .baud_tick(baud_tick), .baud_x16(baud_x16));

// ===== tb/btct_host.sv
// Purpose: host cpu model on the register bus
// Assumes: single word transfers, one slave
// Notes: released write data shows the inverse of the last value
`timescale 1ns/1ps
module btct_host
	import btct_pkg::*;
(
	// clock
	input wire logic mclk,
	// bus
	output btct_pkg::btct_ahb_req_t bus_req,
	input wire btct_pkg::btct_ahb_rsp_t bus_rsp
);
	logic sel = 1'b0;
	logic wr = 1'b0;
	logic [1:0] trans = 2'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	always_comb bus_req = '{sel, addr, trans, wr, 3'h2, wdata, bus_rsp.hreadyout};
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		sel <= 1'b1;
		addr <= a;
		trans <= 2'h2;
		wr <= w;
		do @(posedge mclk); while (bus_rsp.hreadyout !== 1'b1);
		trans <= 2'h0;
		wdata <= w ? d : ~wdata;
		do @(posedge mclk); while (bus_rsp.hreadyout !== 1'b1);
		r = bus_rsp.hrdata;
		wdata <= ~wdata;
		// let the closing edge settle so callers see the registered effect
		#1;
	endtask
endmodule // btct_host

// ===== tb/btct_timing_tb.sv
// Purpose: self-checking bench for btct_timing
// Assumes: counter ticks once per clock on the system source while div2 is clear
// Notes: periods are measured between output events
`timescale 1ns/1ps
module btct_timing_tb;
	import btct_pkg::*;
	logic mclk, sys_rst, rx_load_a, rx_load_b, ct_ext_pin, ct_out, ct_int_req, ct_q;
	logic [1:0] pc;
	logic [3:0] baud_tick, baud_x16;
	logic [31:0] r, first;
	btct_ahb_req_t bus_req;
	btct_ahb_rsp_t bus_rsp;
	int failures, n_compared, n;
	wire logic [4:0] evt = {ct_out ^ ct_q, baud_tick};
	btct_timing uut (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rsp(bus_rsp), .rx_load_a(rx_load_a),
		.rx_load_b(rx_load_b), .ct_ext_pin(ct_ext_pin), .ct_out(ct_out), .ct_int_req(ct_int_req),
		.baud_tick(baud_tick), .baud_x16(baud_x16));
	btct_host host (.mclk(mclk), .bus_req(bus_req), .bus_rsp(bus_rsp));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// pin clock: one rising edge every four cycles
	always @(posedge mclk) begin
		pc <= pc + 2'h1;
		ct_ext_pin <= pc[1];
		ct_q <= ct_out;
	end
	task step; @(posedge mclk); #1; endtask
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d); host.xfer(a, 1'b1, {24'h0, d}, r); endtask
	task rd(input logic [7:0] a); host.xfer(a, 1'b0, 32'h0, r); endtask
	task pre(input logic [15:0] p); wr(OFS_PRE_HIGH, p[15:8]); wr(OFS_PRE_LOW, p[7:0]); endtask
	// third span is taken so that a reconfiguration settles first
	task gap(input int w);
		for (int i = 0; i < 3; i++) begin
			n = 0;
			do begin step(); n++; end while (evt[w] !== 1'b1 && n < 300);
		end
	endtask
	task fall; n = 0; while (ct_out !== 1'b0 && n < 300) begin step(); n++; end endtask
	task rx(input logic b);
		@(posedge mclk);
		if (b) rx_load_b <= 1'b1; else rx_load_a <= 1'b1;
		@(posedge mclk);
		rx_load_a <= 1'b0;
		rx_load_b <= 1'b0;
	endtask
	task results;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task t_baud;
		chk("ct_out", ct_out, 1);
		chk("x16", baud_x16, 4'hf);
		rd(OFS_INT_STATUS); chk("isr", r, 0);
		wr(OFS_CSEL_A, 8'hde); chk("x16", baud_x16[1:0], 2'b01);
		wr(OFS_CSEL_A, 8'h0c); gap(1); chk("tick g0", n, BRG_DIV_G0[12]);
		wr(OFS_AUX_CTRL, 8'h80); gap(1); chk("tick g1", n, BRG_DIV_G1[12]);
		wr(OFS_CLK_OPT, 8'h01); gap(1); chk("tick half", n, BRG_DIV_G1[12]);
		wr(OFS_CLK_OPT, 8'h00);
		$display("test baud done");
	endtask
	task t_timer;
		pre(16'h0020); wr(OFS_AUX_CTRL, 8'h60); wr(OFS_INT_MASK, 8'h08); rd(OFS_START);
		gap(4); chk("half", n, 32'h20);
		rd(OFS_INT_STATUS); chk("ready", r[ISR_CT_BIT], 1);
		chk("int", ct_int_req, 1);
		rd(OFS_STOP); rd(OFS_INT_STATUS); chk("stop", r[ISR_CT_BIT], 0);
		gap(4); chk("after stop", n, 32'h20);
		wr(OFS_CLK_OPT, 8'h01); gap(4); chk("halved", n, 32'h40);
		wr(OFS_CLK_OPT, 8'h00); wr(OFS_AUX_CTRL, 8'h40); pre(16'h0002); rd(OFS_START);
		gap(4); chk("pin", n, 8);
		$display("test timer done");
	endtask
	task t_count;
		wr(OFS_AUX_CTRL, 8'h20); pre(16'h0030); rd(OFS_STOP); rd(OFS_START);
		chk("start", ct_out, 1);
		rd(OFS_LIVE_LOW); first = r; rd(OFS_LIVE_LOW); chk("live", r, first - 32'h2);
		fall(); rd(OFS_INT_STATUS); chk("ready", r[ISR_CT_BIT], 1);
		repeat (100) step();
		chk("low", ct_out, 0);
		rd(OFS_LIVE_HIGH); chk("wrap", r, 32'hff);
		rd(OFS_STOP); rd(OFS_INT_STATUS); chk("stop", r, 0);
		$display("test counter done");
	endtask
	task t_tmo;
		pre(16'h0020); wr(OFS_CMD_A, 8'ha0); rd(OFS_INT_STATUS); chk("on", r, 0);
		repeat (40) step();
		chk("hold", ct_out, 1);
		rx(1'b0); fall(); chk("expiry", n > 28 && n < 40, 1);
		rd(OFS_STOP); rd(OFS_INT_STATUS); chk("no stop", r[ISR_CT_BIT], 1);
		rd(OFS_START); chk("no start", ct_out, 0);
		rx(1'b0); step(); chk("restart", {ct_out, ct_int_req}, 2'b10);
		wr(OFS_CMD_B, 8'ha0);
		repeat (2) begin
			repeat (20) step();
			rx(1'b1);
		end
		chk("either", ct_out, 1);
		fall(); chk("b restarts", n > 28 && n < 40, 1);
		wr(OFS_CMD_A, 8'hc0); wr(OFS_CMD_B, 8'hc0); fall();
		rd(OFS_STOP); rd(OFS_INT_STATUS); chk("off", r, 0);
		$display("test timeout done");
	endtask
	initial begin
		#100000;
		failures++;
		results();
	end
	initial begin
		sys_rst = 1'b1;
		rx_load_a = 1'b0;
		rx_load_b = 1'b0;
		ct_ext_pin = 1'b0;
		pc = 2'h0;
		ct_q = 1'b1;
		failures = 0;
		n_compared = 0;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		step();
		t_baud();
		t_timer();
		t_count();
		t_tmo();
		results();
	end
endmodule // btct_timing_tb
